// ==== include/pidmap_pkg.sv ====
// constants, field positions and types for the identifier mapper and pes header parser
package pidmap_pkg;
   localparam int ID_W = 13;
   localparam int BASE_SHIFT = 4;
   // fixed offsets from the base identifier
   localparam logic [12:0] OFS_MAP = 13'h0000;
   localparam logic [12:0] OFS_VIDEO = 13'h0001;
   localparam logic [12:0] OFS_AUDIO = 13'h0004;
   localparam logic [12:0] OFS_DATA = 13'h000a;
   // apb register byte offsets
   localparam logic [7:0] A_PROG = 8'h00;
   localparam logic [7:0] A_IDS0 = 8'h04;
   localparam logic [7:0] A_IDS1 = 8'h08;
   localparam logic [7:0] A_CHECK = 8'h0c;
   localparam logic [7:0] A_STATUS = 8'h10;
   localparam logic [7:0] A_PESLEN = 8'h14;
   localparam logic [7:0] A_PTS = 8'h18;
   localparam logic [7:0] A_DTS = 8'h1c;
   localparam logic [7:0] A_TSHI = 8'h20;
   localparam logic [7:0] A_SID = 8'h24;
   localparam logic [15:0] PROG_RST = 16'h0000;
   // status bit positions
   localparam int S_TV = 0;
   localparam int S_MISM = 1;
   localparam int S_PTSV = 2;
   localparam int S_DTSV = 3;
   localparam int S_ALIGN = 4;
   localparam int S_TRICK = 5;
   localparam int S_UNB = 6;
   localparam int S_TSERR = 7;
   localparam int S_SCERR = 8;
   // service select codes of the check register
   localparam logic [1:0] SVC_VIDEO = 2'h0;
   localparam logic [1:0] SVC_AUDIO = 2'h1;
   localparam logic [1:0] SVC_DATA = 2'h2;
   localparam logic [1:0] SVC_MAP = 2'h3;
   // fixed pes header byte indexes
   localparam logic [3:0] IDX_SC2 = 4'h2;
   localparam logic [3:0] IDX_SID = 4'h3;
   localparam logic [3:0] IDX_LHI = 4'h4;
   localparam logic [3:0] IDX_LLO = 4'h5;
   localparam logic [3:0] IDX_F1 = 4'h6;
   localparam logic [3:0] IDX_F2 = 4'h7;
   localparam logic [3:0] IDX_HLEN = 4'h8;
   // flag bit positions inside the two flag bytes
   localparam int F1_ALIGN = 2;
   localparam int F2_TRICK = 3;
   localparam int F2_PTS = 7;
   localparam int F2_DTS = 6;
   // timestamp field layout
   localparam logic [7:0] TS_PTS_END = 8'h04;
   localparam logic [7:0] TS_DTS_END = 8'h09;
   localparam logic [3:0] PFX_PTS_ONLY = 4'h2;
   localparam logic [3:0] PFX_PTS_BOTH = 4'h3;
   localparam logic [3:0] PFX_DTS = 4'h1;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_HEAD = 4'b0010,
      ST_HDR = 4'b0100,
      ST_PAY = 4'b1000
   } pes_state_t;
endpackage

// ==== logic/pid_mapper.sv ====
// derives fixed stream identifiers from a program number
`timescale 1ns/1ps
module pid_mapper (
   input wire logic [15:0] program_number,
   input wire logic [12:0] listed_id,
   input wire logic [1:0] listed_svc,
   output logic [12:0] program_base_identifier,
   output logic [12:0] map_table_stream_identifier,
   output logic [12:0] video_stream_identifier,
   output logic [12:0] clock_reference_stream_identifier,
   output logic [12:0] primary_audio_stream_identifier,
   output logic [12:0] data_stream_identifier,
   output logic tv_program,
   output logic listed_mismatch
);
   logic [19:0] shifted; // full shift before trimming to 13 bits
   logic [12:0] expect_id; // fixed identifier of the selected service

   // upper bits of the shift fall away: identifiers are 13 bits wide
   always_comb begin
      shifted = {program_number, 4'h0};
      program_base_identifier = shifted[12:0];
      map_table_stream_identifier =
         program_base_identifier + pidmap_pkg::OFS_MAP;
      video_stream_identifier =
         program_base_identifier + pidmap_pkg::OFS_VIDEO;
      // the video stream also carries the clock reference
      clock_reference_stream_identifier = video_stream_identifier;
      primary_audio_stream_identifier =
         program_base_identifier + pidmap_pkg::OFS_AUDIO;
      data_stream_identifier =
         program_base_identifier + pidmap_pkg::OFS_DATA;
      // only the high byte is needed to recognise television programs
      tv_program = (program_number[15:8] == 8'h00);
   end

   // compare a table-listed identifier with the fixed one
   always_comb begin
      unique case (listed_svc)
         pidmap_pkg::SVC_VIDEO: expect_id = video_stream_identifier;
         pidmap_pkg::SVC_AUDIO: expect_id = primary_audio_stream_identifier;
         pidmap_pkg::SVC_DATA: expect_id = data_stream_identifier;
         pidmap_pkg::SVC_MAP: expect_id = map_table_stream_identifier;
      endcase
      listed_mismatch = (listed_id != expect_id);
   end
endmodule

// ==== logic/ts_field_decode.sv ====
// unpacks one 40-bit timestamp field into prefix and value
`timescale 1ns/1ps
module ts_field_decode (
   input wire logic [39:0] field,
   output logic [3:0] prefix,
   output logic [32:0] stamp,
   output logic markers_ok
);
   // layout: prefix, 3 bits, marker, 15 bits, marker, 15 bits, marker
   always_comb begin
      prefix = field[39:36];
      stamp = {field[35:33], field[31:17], field[15:1]};
      // markers keep long zero runs from mimicking a start code
      markers_ok = field[32] & field[16] & field[0];
   end
endmodule

// ==== logic/program_pid_map_pes_header.sv ====
// apb-controlled identifier mapper and pes header parser
//
// Overview of operation
// - high byte zero marks a television program
// - base identifier is program number shifted four
// - map table stream at base plus zero
// - video and clock reference at base plus one
// - complete main audio at base plus four
// - data stream at base plus ten
// - other services learnt from decoded map table
// - zero length means unbounded, never skip
// - skip exactly header-length bytes to payload
// - presentation stamp only when unit begins
// - missing decode stamp equals presentation stamp
// - prefixes 0010 alone, or 0011 then 0001, before stamp fields
`timescale 1ns/1ps
module program_pid_map_pes_header (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic es_valid,
   input wire logic es_start,
   input wire logic [7:0] es_byte,
   output logic pay_valid,
   output logic [7:0] pay_byte
);
   typedef struct packed {
      pidmap_pkg::pes_state_t st; // parser state
      logic [3:0] idx; // fixed header byte index
      logic [7:0] hcnt; // optional header bytes consumed
      logic [7:0] hlen; // header length byte
      logic [15:0] rem; // bytes left in a bounded packet
      logic [15:0] plen; // packet length field
      logic [7:0] sid; // stream id
      logic [7:0] f1; // first flag byte
      logic [7:0] f2; // second flag byte
      logic [31:0] tsb; // last four header bytes
      logic [32:0] pts; // presentation stamp
      logic [32:0] dts; // decode stamp
      logic pts_v; // presentation stamp seen
      logic dts_v; // decode stamp carried explicitly
      logic [15:0] prog; // program number
      logic [12:0] listed; // identifier listed in map table
      logic [1:0] svc; // service that identifier belongs to
      logic mism; // sticky mismatch
      logic ts_err; // sticky prefix or marker error
      logic sc_err; // sticky start code error
      logic [31:0] rdata; // read data staged in setup
      logic pv; // payload byte valid
      logic [7:0] pb; // payload byte
   } state_t;

   state_t q, d; // registered state and its next value

   logic [12:0] base_id, map_id, vid_id, clk_id, aud_id, data_id;
   logic tv, live_mism;
   logic [3:0] ts_pfx;
   logic [32:0] ts_val;
   logic ts_mk;
   logic wr, rd_setup, mapped, bnd, hdr_last;
   logic [31:0] status, rmux;
   logic [15:0] remn;

   pid_mapper u_map (
      .program_number(q.prog),
      .listed_id(q.listed),
      .listed_svc(q.svc),
      .program_base_identifier(base_id),
      .map_table_stream_identifier(map_id),
      .video_stream_identifier(vid_id),
      .clock_reference_stream_identifier(clk_id),
      .primary_audio_stream_identifier(aud_id),
      .data_stream_identifier(data_id),
      .tv_program(tv),
      .listed_mismatch(live_mism)
   );

   // one decoder serves both stamps: they never end on the same byte
   ts_field_decode u_ts (
      .field({q.tsb, es_byte}),
      .prefix(ts_pfx),
      .stamp(ts_val),
      .markers_ok(ts_mk)
   );

   // bus decode and read mux
   always_comb begin
      wr = psel & penable & pwrite;
      rd_setup = psel & ~penable & ~pwrite;
      mapped = (paddr[1:0] == 2'h0) && (paddr <= pidmap_pkg::A_SID);
      bnd = (q.plen != 16'h0000);
      remn = q.rem - 16'h0001;
      hdr_last = (q.hcnt == q.hlen - 8'h01);
      status = 32'h0;
      status[pidmap_pkg::S_TV] = tv;
      status[pidmap_pkg::S_MISM] = q.mism;
      status[pidmap_pkg::S_PTSV] = q.pts_v;
      status[pidmap_pkg::S_DTSV] = q.dts_v;
      status[pidmap_pkg::S_ALIGN] = q.f1[pidmap_pkg::F1_ALIGN];
      status[pidmap_pkg::S_TRICK] = q.f2[pidmap_pkg::F2_TRICK];
      status[pidmap_pkg::S_UNB] = ~bnd;
      status[pidmap_pkg::S_TSERR] = q.ts_err;
      status[pidmap_pkg::S_SCERR] = q.sc_err;
      unique case (paddr)
         pidmap_pkg::A_PROG: rmux = {16'h0, q.prog};
         pidmap_pkg::A_IDS0: rmux = {3'h0, vid_id, 3'h0, map_id};
         pidmap_pkg::A_IDS1: rmux = {3'h0, data_id, 3'h0, aud_id};
         pidmap_pkg::A_CHECK: rmux = {14'h0, q.svc, 3'h0, q.listed};
         pidmap_pkg::A_STATUS: rmux = status;
         pidmap_pkg::A_PESLEN: rmux = {8'h0, q.hlen, q.plen};
         pidmap_pkg::A_PTS: rmux = q.pts[31:0];
         pidmap_pkg::A_DTS: rmux = q.dts[31:0];
         pidmap_pkg::A_TSHI: rmux = {15'h0, q.dts[32], 15'h0, q.pts[32]};
         pidmap_pkg::A_SID: rmux = {11'h0, clk_id, q.sid};
         default: rmux = 32'h0;
      endcase
      // zero wait: read data is staged during the setup cycle
      pready = psel & penable;
      pslverr = psel & penable & ~mapped;
      prdata = q.rdata;
      pay_valid = q.pv;
      pay_byte = q.pb;
   end

   // next-state logic for registers and parser
   always_comb begin
      d = q;
      d.pv = 1'b0;
      if (rd_setup) begin
         d.rdata = rmux;
      end
      // register writes
      if (wr && paddr == pidmap_pkg::A_PROG) begin
         d.prog = pwdata[15:0];
      end
      // software hands in identifiers it decoded from the map table
      if (wr && paddr == pidmap_pkg::A_CHECK) begin
         d.listed = pwdata[12:0];
         d.svc = pwdata[17:16];
      end
      // write one to clear; a same-cycle set below still wins
      if (wr && paddr == pidmap_pkg::A_STATUS) begin
         if (pwdata[pidmap_pkg::S_MISM]) d.mism = 1'b0;
         if (pwdata[pidmap_pkg::S_TSERR]) d.ts_err = 1'b0;
         if (pwdata[pidmap_pkg::S_SCERR]) d.sc_err = 1'b0;
      end
      if (live_mism) begin
         d.mism = 1'b1;
      end
      // byte stream parser
      if (es_valid && es_start) begin
         // a new packet always restarts the parser
         d.pts_v = 1'b0;
         d.dts_v = 1'b0;
         d.idx = 4'h1;
         if (es_byte == 8'h00) begin
            d.st = pidmap_pkg::ST_HEAD;
         end else begin
            d.st = pidmap_pkg::ST_IDLE;
            d.sc_err = 1'b1;
         end
      end else if (es_valid) begin
         if (bnd && q.st != pidmap_pkg::ST_IDLE &&
             q.idx > pidmap_pkg::IDX_LLO) begin
            d.rem = remn;
         end
         unique case (q.st)
            pidmap_pkg::ST_IDLE: begin
               d.st = pidmap_pkg::ST_IDLE; // wait for a packet start
            end
            pidmap_pkg::ST_HEAD: begin
               d.idx = q.idx + 4'h1;
               if (q.idx < pidmap_pkg::IDX_SC2) begin
                  if (es_byte != 8'h00) begin
                     d.st = pidmap_pkg::ST_IDLE;
                     d.sc_err = 1'b1;
                  end
               end else if (q.idx == pidmap_pkg::IDX_SC2) begin
                  if (es_byte != 8'h01) begin
                     d.st = pidmap_pkg::ST_IDLE;
                     d.sc_err = 1'b1;
                  end
               end
               if (q.idx == pidmap_pkg::IDX_SID) d.sid = es_byte;
               if (q.idx == pidmap_pkg::IDX_LHI) d.plen[15:8] = es_byte;
               // zero length is kept as unbounded, not as a skip count
               if (q.idx == pidmap_pkg::IDX_LLO) begin
                  d.plen[7:0] = es_byte;
                  d.rem = {q.plen[15:8], es_byte};
               end
               if (q.idx == pidmap_pkg::IDX_F1) d.f1 = es_byte;
               if (q.idx == pidmap_pkg::IDX_F2) d.f2 = es_byte;
               if (q.idx == pidmap_pkg::IDX_HLEN) begin
                  d.hlen = es_byte;
                  d.hcnt = 8'h00;
                  if (es_byte != 8'h00) begin
                     d.st = pidmap_pkg::ST_HDR;
                  end else if (bnd && remn == 16'h0000) begin
                     d.st = pidmap_pkg::ST_IDLE;
                  end else begin
                     d.st = pidmap_pkg::ST_PAY;
                  end
               end
            end
            pidmap_pkg::ST_HDR: begin
               d.hcnt = q.hcnt + 8'h01;
               d.tsb = {q.tsb[23:0], es_byte};
               // presentation stamp only where the flags announce it
               if (q.f2[pidmap_pkg::F2_PTS] &&
                   q.hcnt == pidmap_pkg::TS_PTS_END) begin
                  d.pts = ts_val;
                  d.pts_v = 1'b1;
                  if (!q.f2[pidmap_pkg::F2_DTS]) begin
                     d.dts = ts_val;
                     if (ts_pfx != pidmap_pkg::PFX_PTS_ONLY || !ts_mk)
                        d.ts_err = 1'b1;
                  end else if (ts_pfx != pidmap_pkg::PFX_PTS_BOTH ||
                               !ts_mk) begin
                     d.ts_err = 1'b1;
                  end
               end
               if (q.f2[pidmap_pkg::F2_PTS] && q.f2[pidmap_pkg::F2_DTS] &&
                   q.hcnt == pidmap_pkg::TS_DTS_END) begin
                  d.dts = ts_val;
                  d.dts_v = 1'b1;
                  if (ts_pfx != pidmap_pkg::PFX_DTS || !ts_mk)
                     d.ts_err = 1'b1;
               end
               // stuffing and extensions are skipped by count alone
               if (hdr_last) begin
                  if (bnd && remn == 16'h0000) begin
                     d.st = pidmap_pkg::ST_IDLE;
                  end else begin
                     d.st = pidmap_pkg::ST_PAY;
                  end
               end
            end
            pidmap_pkg::ST_PAY: begin
               d.pv = 1'b1;
               d.pb = es_byte;
               if (bnd && q.rem == 16'h0001) begin
                  d.st = pidmap_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.st <= pidmap_pkg::ST_IDLE;
         q.prog <= pidmap_pkg::PROG_RST;
      end else begin
         q <= d;
      end
   end

   property p_map_id;
      @(posedge pclk) disable iff (!presetn)
         wr && paddr == pidmap_pkg::A_PROG |=>
            map_id == {$past(pwdata[8:0]), 4'h0} && map_id == base_id;
   endproperty
   a_map_id: assert property (p_map_id) else $error("map id wrong");
   property p_video;
      @(posedge pclk) disable iff (!presetn)
         vid_id == map_id + 13'h0001 && clk_id == vid_id;
   endproperty
   a_video: assert property (p_video) else $error("video id wrong");
   property p_audio_data;
      @(posedge pclk) disable iff (!presetn)
         aud_id - map_id == 13'h0004 && data_id - aud_id == 13'h0006;
   endproperty
   a_audio_data: assert property (p_audio_data)
      else $error("audio or data id wrong");
   property p_tv;
      @(posedge pclk) disable iff (!presetn)
         wr && paddr == pidmap_pkg::A_PROG && pwdata[15:8] == 8'h00
            |=> tv;
   endproperty
   a_tv: assert property (p_tv) else $error("tv class wrong");
   property p_skip;
      @(posedge pclk) disable iff (!presetn)
         q.st == pidmap_pkg::ST_HDR && es_valid && !es_start && hdr_last
            |=> q.st != pidmap_pkg::ST_HDR;
   endproperty
   a_skip: assert property (p_skip) else $error("header overrun");
   property p_unbounded;
      @(posedge pclk) disable iff (!presetn)
         q.st == pidmap_pkg::ST_PAY && !bnd && es_valid && !es_start
            |=> q.st == pidmap_pkg::ST_PAY ##0 pay_valid;
   endproperty
   a_unbounded: assert property (p_unbounded)
      else $error("unbounded packet cut");
   property p_dts;
      @(posedge pclk) disable iff (!presetn)
         q.st == pidmap_pkg::ST_HDR && es_valid && !es_start &&
         q.hcnt == pidmap_pkg::TS_PTS_END &&
         q.f2[pidmap_pkg::F2_PTS] && !q.f2[pidmap_pkg::F2_DTS]
            |=> q.dts == q.pts && q.pts_v && !q.dts_v;
   endproperty
   a_dts: assert property (p_dts) else $error("dts not from pts");
   property p_prefix;
      @(posedge pclk) disable iff (!presetn)
         q.st == pidmap_pkg::ST_HDR && es_valid && !es_start &&
         q.hcnt == pidmap_pkg::TS_DTS_END && q.f2[7:6] == 2'h3 &&
         ts_pfx != pidmap_pkg::PFX_DTS |=> q.ts_err;
   endproperty
   a_prefix: assert property (p_prefix) else $error("prefix missed");
   property p_mism;
      @(posedge pclk) disable iff (!presetn)
         live_mism |=> q.mism [*2];
   endproperty
   a_mism: assert property (p_mism) else $error("mismatch lost");
endmodule

// ==== tb/es_source.sv ====
// stream source standing in for the transport multiplexer
`timescale 1ns/1ps
module es_source (
   input wire logic pclk,
   input wire logic presetn,
   output logic es_valid,
   output logic es_start,
   output logic [7:0] es_byte
);
   logic [8:0] q[$]; // bit 8 marks the first byte of a packet
   logic slow = 1'b0; // set by the bench: a gap after each byte
   logic gap = 1'b0; // pending idle cycle in slow mode
   logic [8:0] item; // byte being launched

   // only pes packets leave this model, never a table section, so the
   // section-zero, one-program, adaptation and spacing limits hold
   initial begin
      es_valid = 1'b0;
      es_start = 1'b0;
      es_byte = 8'h00;
   end

   // at most one byte per edge; an idle line toggles so no stale byte lingers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         es_valid <= 1'b0;
         es_start <= 1'b0;
         gap <= 1'b0;
      end else if (q.size() > 0 && !gap) begin
         item = q.pop_front();
         es_valid <= 1'b1;
         es_start <= item[8];
         es_byte <= item[7:0];
         gap <= slow;
      end else begin
         es_valid <= 1'b0;
         es_start <= 1'b0;
         es_byte <= ~es_byte;
         gap <= 1'b0;
      end
   end
endmodule

// ==== tb/tb.sv ====
// self-checking bench for the identifier mapper and pes header parser
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin \
   bad_count++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module tb;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, es_valid, es_start, pay_valid;
   logic [7:0] es_byte, pay_byte;
   int bad_count = 0;
   int checks = 0;
   logic [7:0] pk[$]; // packet under construction
   logic [7:0] exp_q[$]; // payload bytes still expected
   logic [31:0] rd;
   logic er;

   always #50 pclk = ~pclk;

   program_pid_map_pes_header dut_u (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .es_valid(es_valid), .es_start(es_start),
      .es_byte(es_byte), .pay_valid(pay_valid), .pay_byte(pay_byte));
   es_source src_u (.pclk(pclk), .presetn(presetn), .es_valid(es_valid),
      .es_start(es_start), .es_byte(es_byte));

   // payload watch at the falling edge, where registered outputs settled
   always @(negedge pclk) begin
      logic [7:0] e;
      if (pay_valid === 1'b1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : ~pay_byte;
         `CHK("payload", e, pay_byte)
      end
   end

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin
         bad_count++;
         complete_run();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // 40-bit stamp field: prefix, value split by marker ones
   function automatic logic [39:0] tsf(input logic [3:0] p,
                                       input logic [32:0] t);
      return {p, t[32:30], 1'b1, t[29:15], 1'b1, t[14:0], 1'b1};
   endfunction

   // hand the packet to the source and wait for it to drain
   task automatic send(input logic sl);
      int n;
      src_u.slow = sl;
      foreach (pk[i]) src_u.q.push_back({i == 0, pk[i]});
      pk.delete();
      n = 0;
      while (src_u.q.size() > 0 && n < 2000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 2000) begin
         bad_count++;
         complete_run();
      end
      repeat (4) @(posedge pclk);
      `CHK("payload left", 32'h0, 32'(exp_q.size()))
   endtask

   // identifiers for a set of program numbers incl. truncating ones
   task automatic t_map;
      logic [15:0] pg[6] = '{16'h0034, 16'h0001, 16'h00ff, 16'h0100,
                             16'h0fff, 16'h1234};
      logic [12:0] b;
      foreach (pg[i]) begin
         b = {pg[i][8:0], 4'h0};
         apb(1'b1, pidmap_pkg::A_PROG, {16'h0, pg[i]});
         apb(1'b0, pidmap_pkg::A_IDS0, 32'h0);
         `CHK("ids0", {3'h0, b + pidmap_pkg::OFS_VIDEO, 3'h0, b}, rd)
         apb(1'b0, pidmap_pkg::A_IDS1, 32'h0);
         `CHK("ids1", {3'h0, b + pidmap_pkg::OFS_DATA, 3'h0,
                       b + pidmap_pkg::OFS_AUDIO}, rd)
         `CHK("span", 1'b1, (rd[28:16] - b) < 13'h0010)
         apb(1'b0, pidmap_pkg::A_SID, 32'h0);
         `CHK("clkref", b + pidmap_pkg::OFS_VIDEO, rd[20:8])
         apb(1'b0, pidmap_pkg::A_STATUS, 32'h0);
         `CHK("tv", pg[i][15:8] == 8'h0, rd[pidmap_pkg::S_TV])
      end
      $display("t_map done");
   endtask

   // listed identifiers: after a clear a match leaves the flag low, differing sets it
   task automatic t_check;
      logic [1:0] sv[4] = '{pidmap_pkg::SVC_VIDEO, pidmap_pkg::SVC_AUDIO,
                            pidmap_pkg::SVC_DATA, pidmap_pkg::SVC_MAP};
      logic [12:0] of[4] = '{pidmap_pkg::OFS_VIDEO, pidmap_pkg::OFS_AUDIO,
                             pidmap_pkg::OFS_DATA, pidmap_pkg::OFS_MAP};
      apb(1'b1, pidmap_pkg::A_PROG, 32'h0000_0034);
      foreach (sv[i]) begin
         apb(1'b1, pidmap_pkg::A_CHECK, {14'h0, sv[i], 3'h0,
                                         13'h0340 + of[i]});
         apb(1'b1, pidmap_pkg::A_STATUS, 32'h0000_0002);
         apb(1'b0, pidmap_pkg::A_STATUS, 32'h0);
         `CHK("match", 1'b0, rd[pidmap_pkg::S_MISM])
         apb(1'b1, pidmap_pkg::A_CHECK, {14'h0, sv[i], 3'h0, 13'h0342});
         apb(1'b0, pidmap_pkg::A_STATUS, 32'h0);
         `CHK("mismatch", 1'b1, rd[pidmap_pkg::S_MISM])
      end
      apb(1'b0, 8'h28, 32'h0);
      `CHK("unmapped err", 1'b1, er)
      `CHK("unmapped data", 32'h0, rd)
      apb(1'b1, 8'h02, 32'hffff_ffff);
      `CHK("unaligned err", 1'b1, er)
      apb(1'b0, pidmap_pkg::A_PROG, 32'h0);
      `CHK("prog kept", 32'h0000_0034, rd)
      $display("t_check done");
   endtask

   // bounded packet, both stamps, stuffing, trailing bytes ignored
   task automatic t_both;
      logic [32:0] p = 33'h1_2345_6789;
      logic [32:0] d = 33'h0_8765_4321;
      logic [39:0] f;
      pk = '{8'h00, 8'h00, 8'h01, 8'he0, 8'h00, 8'd20, 8'h84, 8'hc0, 8'd12};
      f = tsf(pidmap_pkg::PFX_PTS_BOTH, p);
      for (int i = 4; i >= 0; i--) pk.push_back(f[i*8 +: 8]);
      f = tsf(pidmap_pkg::PFX_DTS, d);
      for (int i = 4; i >= 0; i--) pk.push_back(f[i*8 +: 8]);
      pk.push_back(8'hff);
      pk.push_back(8'hff);
      exp_q = '{8'h00, 8'h00, 8'h01, 8'hb3, 8'h5a};
      pk = {pk, exp_q, 8'h11, 8'h22};
      send(1'b0);
      apb(1'b0, pidmap_pkg::A_PTS, 32'h0);
      `CHK("pts", p[31:0], rd)
      apb(1'b0, pidmap_pkg::A_DTS, 32'h0);
      `CHK("dts", d[31:0], rd)
      apb(1'b0, pidmap_pkg::A_TSHI, 32'h0);
      `CHK("ts hi", 32'h0000_0001, rd)
      apb(1'b0, pidmap_pkg::A_PESLEN, 32'h0);
      `CHK("peslen", 32'h000c_0014, rd)
      apb(1'b0, pidmap_pkg::A_STATUS, 32'h0);
      `CHK("flags", 5'b00011, rd[7:3])
      `CHK("pts seen", 1'b1, rd[pidmap_pkg::S_PTSV])
      $display("t_both done");
   endtask

   // unbounded packet, presentation stamp only, slow source
   task automatic t_pts;
      logic [32:0] p = 33'h1_0000_abcd;
      logic [39:0] f;
      pk = '{8'h00, 8'h00, 8'h01, 8'he0, 8'h00, 8'h00, 8'h84, 8'h80, 8'd8};
      f = tsf(pidmap_pkg::PFX_PTS_ONLY, p);
      for (int i = 4; i >= 0; i--) pk.push_back(f[i*8 +: 8]);
      pk = {pk, 8'hff, 8'hff, 8'hff};
      exp_q = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h3c, 8'h7e};
      pk = {pk, exp_q};
      send(1'b1);
      apb(1'b0, pidmap_pkg::A_DTS, 32'h0);
      `CHK("dts copy", p[31:0], rd)
      apb(1'b0, pidmap_pkg::A_TSHI, 32'h0);
      `CHK("ts hi copy", 32'h0001_0001, rd)
      apb(1'b0, pidmap_pkg::A_STATUS, 32'h0);
      `CHK("unbounded", 1'b1, rd[pidmap_pkg::S_UNB])
      `CHK("no dts", 1'b0, rd[pidmap_pkg::S_DTSV])
      `CHK("pts seen", 1'b1, rd[pidmap_pkg::S_PTSV])
      $display("t_pts done");
   endtask

   // broken start code, then a wrong decode prefix: no payload comes out
   task automatic t_bad;
      logic [39:0] f;
      pk = '{8'h00, 8'h00, 8'h02, 8'he0, 8'h00, 8'h05, 8'h84, 8'h00, 8'h00,
             8'h55, 8'h66};
      send(1'b0);
      apb(1'b0, pidmap_pkg::A_STATUS, 32'h0);
      `CHK("start err", 1'b1, rd[pidmap_pkg::S_SCERR])
      pk = '{8'h00, 8'h00, 8'h01, 8'he0, 8'h00, 8'd13, 8'h84, 8'hc0, 8'd10};
      f = tsf(pidmap_pkg::PFX_PTS_BOTH, 33'h0);
      for (int i = 4; i >= 0; i--) pk.push_back(f[i*8 +: 8]);
      f = tsf(pidmap_pkg::PFX_PTS_ONLY, 33'h0); // not the decode prefix
      for (int i = 4; i >= 0; i--) pk.push_back(f[i*8 +: 8]);
      send(1'b0);
      apb(1'b0, pidmap_pkg::A_STATUS, 32'h0);
      `CHK("stamp err", 1'b1, rd[pidmap_pkg::S_TSERR])
      apb(1'b1, pidmap_pkg::A_STATUS, 32'h0000_0180);
      apb(1'b0, pidmap_pkg::A_STATUS, 32'h0);
      `CHK("err cleared", 1'b0, rd[pidmap_pkg::S_SCERR])
      `CHK("stamp err cleared", 1'b0, rd[pidmap_pkg::S_TSERR])
      $display("t_bad done");
   endtask

   // mid-run reset: program number and presentation stamp flag return to reset
   task automatic t_reset;
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      `CHK("reset pay", 1'b0, pay_valid)
      `CHK("reset rdata", 32'h0, prdata)
      presetn <= 1'b1;
      apb(1'b0, pidmap_pkg::A_PROG, 32'h0);
      `CHK("reset prog", 32'h0, rd)
      apb(1'b0, pidmap_pkg::A_STATUS, 32'h0);
      `CHK("reset pts seen", 1'b0, rd[pidmap_pkg::S_PTSV])
      $display("t_reset done");
   endtask

   // reset, then every scenario in turn
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, pidmap_pkg::A_IDS1, 32'h0);
      `CHK("reset ids1", 32'h000a_0004, rd)
      t_map();
      t_check();
      t_bad();
      t_both();
      t_pts();
      t_reset();
      complete_run();
   end
endmodule
